/* rtl/apc_pkg.sv */
// package: register map, field layout and types for the aux chip-select port
package apc_pkg;
	localparam int APC_PINS = 4;
	localparam logic [7:0] APC_ADDR_POLARITY = 8'hae;
	localparam logic [7:0] APC_ADDR_CFG_LOW = 8'hc2;
	localparam logic [7:0] APC_ADDR_CFG_HIGH = 8'hc3;
	localparam logic [7:0] APC_ADDR_DATA = 8'hd8;
	localparam logic [7:0] APC_ADDR_CS0_LOW = 8'h84;
	localparam logic [7:0] APC_ADDR_CS0_HIGH = 8'h85;
	localparam logic [7:0] APC_ADDR_CS1_LOW = 8'h94;
	localparam logic [7:0] APC_ADDR_CS1_HIGH = 8'h95;
	localparam logic [7:0] APC_ADDR_CS2_LOW = 8'hac;
	localparam logic [7:0] APC_ADDR_CS2_HIGH = 8'had;
	localparam logic [7:0] APC_ADDR_CS3_LOW = 8'hb4;
	localparam logic [7:0] APC_ADDR_CS3_HIGH = 8'hb5;
	localparam logic [7:0] APC_RST_CFG = 8'h00;
	localparam logic [7:0] APC_RST_POLARITY = 8'h00;
	localparam logic [3:0] APC_RST_DATA = 4'hf;
	localparam logic [7:0] APC_POL_WMASK = 8'hf0;
	localparam logic [3:0] APC_DATA_RSVD_READ = 4'h0;
	localparam int APC_POL_LSB = 4;
	localparam int APC_FUNC_LSB = 2;
	localparam int APC_CMP_LSB = 0;
	localparam int APC_PIN_FIELD_W = 4;
	localparam logic [15:0] APC_MASK_FULL = 16'hffff;
	localparam logic [15:0] APC_MASK_A1 = 16'hfffe;
	localparam logic [15:0] APC_MASK_A2 = 16'hfffc;
	localparam logic [15:0] APC_MASK_A8 = 16'hff00;

	typedef enum logic [1:0] {
		APC_FN_GPIO = 2'h0,
		APC_FN_READ = 2'h1,
		APC_FN_WRITE = 2'h2,
		APC_FN_EITHER = 2'h3
	} apc_func_t;

	typedef enum logic [1:0] {
		APC_CMP_16 = 2'h0,
		APC_CMP_15 = 2'h1,
		APC_CMP_14 = 2'h2,
		APC_CMP_8 = 2'h3
	} apc_cmp_t;

	// per-pin settings handed to the decoder
	typedef struct packed {
		apc_func_t func;
		apc_cmp_t cmp;
		logic active_high;
		logic [15:0] base;
	} apc_pin_cfg_t;

	// external bus access seen by the decoders
	typedef struct packed {
		logic [15:0] addr;
		logic rd;
		logic wr;
	} apc_bus_t;

	// special-function register port from the core
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
	} apc_sfr_t;
endpackage

/* rtl/apc_match.sv */
// address compare for one strobe pin under the chosen compare length
module apc_match
	import apc_pkg::*;
(
	input wire logic [15:0] addr,
	input wire logic [15:0] base,
	input wire apc_cmp_t cmp,
	output logic hit
);
	logic [15:0] mask;

	// select the compared address bits
	always_comb begin
		case (cmp)
			APC_CMP_16: mask = APC_MASK_FULL; // R6
			APC_CMP_15: mask = APC_MASK_A1; // R7
			APC_CMP_14: mask = APC_MASK_A2; // R8
			APC_CMP_8: mask = APC_MASK_A8; // R9
			default: mask = APC_MASK_FULL;
		endcase
		hit = ((addr ^ base) & mask) == 16'h0000;
	end
endmodule

/* rtl/apc_strobe.sv */
// strobe generator for one pin: mode select and polarity
module apc_strobe
	import apc_pkg::*;
(
	input wire apc_pin_cfg_t cfg,
	input wire apc_bus_t bus,
	input wire logic gpio_bit,
	output logic pin_level,
	output logic strobe_active
);
	logic hit;

	apc_match u_match (
		.addr(bus.addr),
		.base(cfg.base),
		.cmp(cfg.cmp),
		.hit(hit)
	);

	// active when the chosen bus strobe meets an address hit
	always_comb begin
		case (cfg.func)
			APC_FN_READ: strobe_active = hit & bus.rd; // R2
			APC_FN_WRITE: strobe_active = hit & bus.wr; // R3
			APC_FN_EITHER: strobe_active = hit & (bus.rd | bus.wr); // R4
			default: strobe_active = 1'b0;
		endcase
		if (cfg.func == APC_FN_GPIO) begin
			pin_level = gpio_bit; // R1
		end else begin
			pin_level = cfg.active_high ? strobe_active : ~strobe_active; // R21
		end
	end
endmodule

/* rtl/apc_port.sv */
// auxiliary four-pin port: register file, chip-select strobes, pin drivers
// Notes on behaviour
// (R1) function 00 makes the pin a plain quasi-bidirectional port bit.
// (R2) function 01 makes the pin a read strobe for matching addresses.
// (R3) function 10 makes the pin a write strobe for matching addresses.
// (R4) function 11 asserts the strobe on matching reads or writes.
// (R5) pin 3 function at bits 7:6, compare length 5:4, high config.
// (R6) compare length 00 compares all sixteen address bits.
// (R7) compare length 01 ignores address bit 0.
// (R8) compare length 10 ignores address bits 1 and 0.
// (R9) compare length 11 ignores the whole low address byte.
// (R10) pin 2 function at bits 3:2 of the high config register.
// (R11) pin 2 compare length at bits 1:0 of the high config register.
// (R12) pin 1 function 7:6, compare length 5:4 of low config register.
// (R13) pin 0 function 3:2, compare length 1:0 of low config register.
// (R14) polarity bit 7 high makes pin 3 strobe active high.
// (R15) polarity bits 6,5,4 do the same for pins 2,1,0.
// (R16) each pin has a sixteen-bit base from high and low byte registers.
// (R17) data bits 3:0 drive port pins in general mode; 7:4 reserved.
// (R18) matching external data write pulses a write-strobe pin at its polarity.
// (R19) read strobe window coincides with the bus read strobe; the registered pin follows it one core clock later.
// (R20) write strobe window coincides with the bus write strobe; the registered pin follows it one core clock later.
// (R21) a strobe pin with no matching access idles at its inactive level.
module apc_port
	import apc_pkg::*;
#(
	parameter int PINS = APC_PINS
)
(
	input wire logic core_clk,
	input wire logic rst,
	input wire apc_sfr_t sfr,
	input wire logic [7:0] sfr_raddr,
	output logic [7:0] sfr_rdata,
	input wire apc_bus_t bus,
	input wire logic [PINS-1:0] aux_pin_in,
	output logic [PINS-1:0] aux_pin_out,
	output logic [PINS-1:0] aux_pin_oe
);
	// whole register state of the port
	typedef struct packed {
		logic [7:0] cfg_low;
		logic [7:0] cfg_high;
		logic [7:0] polarity;
		logic [3:0] data;
		logic [3:0][7:0] base_high;
		logic [3:0][7:0] base_low;
		logic [7:0] rdata;
		logic [3:0] pin_out;
		logic [3:0] pin_oe;
	} apc_state_t;

	apc_state_t st;
	apc_state_t next_st;
	apc_pin_cfg_t [PINS-1:0] pin_cfg;
	logic [PINS-1:0] pin_level;
	logic [PINS-1:0] strobe_active;
	logic [15:0] cfg_pair;

	// pin n uses the nibble at n*4 of the config pair
	assign cfg_pair = {st.cfg_high, st.cfg_low}; // R5 R10 R11 R12 R13

	// one strobe generator per pin
	genvar gi;
	generate
		for (gi = 0; gi < PINS; gi++) begin : g_pin
			always_comb begin
				pin_cfg[gi].func = apc_func_t'(cfg_pair[gi*APC_PIN_FIELD_W+APC_FUNC_LSB +: 2]);
				pin_cfg[gi].cmp = apc_cmp_t'(cfg_pair[gi*APC_PIN_FIELD_W+APC_CMP_LSB +: 2]);
				pin_cfg[gi].active_high = st.polarity[APC_POL_LSB+gi]; // R14 R15
				pin_cfg[gi].base = {st.base_high[gi], st.base_low[gi]}; // R16
			end
			apc_strobe u_strobe (
				.cfg(pin_cfg[gi]),
				.bus(bus),
				.gpio_bit(st.data[gi]),
				.pin_level(pin_level[gi]),
				.strobe_active(strobe_active[gi])
			);
		end
	endgenerate

	// register writes, read mux and pin drive
	always_comb begin
		next_st = st;
		if (sfr.wr) begin
			case (sfr.addr)
				APC_ADDR_CFG_LOW: next_st.cfg_low = sfr.wdata;
				APC_ADDR_CFG_HIGH: next_st.cfg_high = sfr.wdata;
				APC_ADDR_POLARITY: next_st.polarity = sfr.wdata & APC_POL_WMASK;
				APC_ADDR_DATA: next_st.data = sfr.wdata[3:0]; // R17
				APC_ADDR_CS0_HIGH: next_st.base_high[0] = sfr.wdata;
				APC_ADDR_CS0_LOW: next_st.base_low[0] = sfr.wdata;
				APC_ADDR_CS1_HIGH: next_st.base_high[1] = sfr.wdata;
				APC_ADDR_CS1_LOW: next_st.base_low[1] = sfr.wdata;
				APC_ADDR_CS2_HIGH: next_st.base_high[2] = sfr.wdata;
				APC_ADDR_CS2_LOW: next_st.base_low[2] = sfr.wdata;
				APC_ADDR_CS3_HIGH: next_st.base_high[3] = sfr.wdata;
				APC_ADDR_CS3_LOW: next_st.base_low[3] = sfr.wdata;
				default: next_st.data = st.data;
			endcase
		end
		case (sfr_raddr)
			APC_ADDR_CFG_LOW: next_st.rdata = st.cfg_low;
			APC_ADDR_CFG_HIGH: next_st.rdata = st.cfg_high;
			APC_ADDR_POLARITY: next_st.rdata = st.polarity;
			APC_ADDR_DATA: next_st.rdata = {APC_DATA_RSVD_READ, aux_pin_in}; // R17
			APC_ADDR_CS0_HIGH: next_st.rdata = st.base_high[0];
			APC_ADDR_CS0_LOW: next_st.rdata = st.base_low[0];
			APC_ADDR_CS1_HIGH: next_st.rdata = st.base_high[1];
			APC_ADDR_CS1_LOW: next_st.rdata = st.base_low[1];
			APC_ADDR_CS2_HIGH: next_st.rdata = st.base_high[2];
			APC_ADDR_CS2_LOW: next_st.rdata = st.base_low[2];
			APC_ADDR_CS3_HIGH: next_st.rdata = st.base_high[3];
			APC_ADDR_CS3_LOW: next_st.rdata = st.base_low[3];
			default: next_st.rdata = 8'h00;
		endcase
		// quasi-bidirectional: drive low always, drive high only as a strobe
		for (int i = 0; i < PINS; i++) begin
			next_st.pin_out[i] = pin_level[i]; // R18 R19 R20
			if (pin_cfg[i].func == APC_FN_GPIO) begin
				next_st.pin_oe[i] = ~pin_level[i]; // R1
			end else begin
				next_st.pin_oe[i] = 1'b1;
			end
		end
	end

	// state register
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			st.cfg_low <= APC_RST_CFG;
			st.cfg_high <= APC_RST_CFG;
			st.polarity <= APC_RST_POLARITY;
			st.data <= APC_RST_DATA;
			st.base_high <= '0;
			st.base_low <= '0;
			st.rdata <= 8'h00;
			st.pin_out <= APC_RST_DATA;
			st.pin_oe <= 4'h0;
		end else begin
			st <= next_st;
		end
	end

	assign sfr_rdata = st.rdata;
	assign aux_pin_out = st.pin_out;
	assign aux_pin_oe = st.pin_oe;

	// strobe pins follow the bus strobe and hit one cycle later
	a_read_strobe: assert property (@(posedge core_clk) disable iff (rst) // R19
		(pin_cfg[0].func == APC_FN_READ && !bus.rd) |=> (aux_pin_out[0] == !$past(st.polarity[4])))
		else $error("read strobe pin active without read");
	a_write_strobe: assert property (@(posedge core_clk) disable iff (rst) // R20
		(pin_cfg[1].func == APC_FN_WRITE && !bus.wr) |=> (aux_pin_out[1] == !$past(st.polarity[5])))
		else $error("write strobe pin active without write");
	a_full_match: assert property (@(posedge core_clk) disable iff (rst) // R6
		(pin_cfg[2].func == APC_FN_EITHER && pin_cfg[2].cmp == APC_CMP_16 && (bus.rd || bus.wr)
		&& bus.addr == pin_cfg[2].base) |=> (aux_pin_out[2] == $past(st.polarity[6])))
		else $error("full compare hit not strobed");
	a_byte_match: assert property (@(posedge core_clk) disable iff (rst) // R9
		(pin_cfg[3].func == APC_FN_EITHER && pin_cfg[3].cmp == APC_CMP_8 && (bus.rd || bus.wr)
		&& bus.addr[15:8] == pin_cfg[3].base[15:8]) |=> (aux_pin_out[3] == $past(st.polarity[7])))
		else $error("high byte compare hit not strobed");
	a_gpio_drive: assert property (@(posedge core_clk) disable iff (rst) // R1
		(pin_cfg[0].func == APC_FN_GPIO) |=> (aux_pin_oe[0] == !aux_pin_out[0]))
		else $error("gpio pin enable wrong");
	a_data_write: assert property (@(posedge core_clk) disable iff (rst) // R17
		(sfr.wr && sfr.addr == APC_ADDR_DATA) |=> (st.data == $past(sfr.wdata[3:0])))
		else $error("data register not written");
	a_cfg_write: assert property (@(posedge core_clk) disable iff (rst) // R5
		(sfr.wr && sfr.addr == APC_ADDR_CFG_HIGH) |=> ##1 (st.rdata == $past(st.cfg_high)
		|| $past(sfr_raddr) != APC_ADDR_CFG_HIGH))
		else $error("config readback mismatch");
	a_strobe_idle: assert property (@(posedge core_clk) disable iff (rst) // R21
		(pin_cfg[1].func != APC_FN_GPIO && !strobe_active[1])
		|=> (aux_pin_out[1] != $past(st.polarity[5])))
		else $error("idle strobe not inactive");
	a_strobe_drive: assert property (@(posedge core_clk) disable iff (rst) // R21
		(pin_cfg[0].func != APC_FN_GPIO) |=> aux_pin_oe[0])
		else $error("strobe pin not driven");
endmodule

/* testbench/apc_pin_load.sv */
// pin load model: pull-ups on the four pins and a peripheral that can pull them low
module apc_pin_load
	import apc_pkg::*;
(
	input wire logic [APC_PINS-1:0] pin_out,
	input wire logic [APC_PINS-1:0] pin_oe,
	input wire logic [APC_PINS-1:0] ext_pull_low,
	output logic [APC_PINS-1:0] pin_level
);
	timeunit 1ns;
	timeprecision 1ps;
	// a driven pin shows the port level, a released one floats up unless pulled low
	always_comb begin
		for (int i = 0; i < APC_PINS; i++) begin
			pin_level[i] = pin_oe[i] ? pin_out[i] : !ext_pull_low[i];
		end
	end
endmodule

/* testbench/apc_port_tb.sv */
// self-checking bench for the aux chip-select port
module apc_port_tb
	import apc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	apc_sfr_t sfr = '0;
	logic [7:0] sfr_raddr = 8'h00;
	logic [7:0] sfr_rdata;
	apc_bus_t bus = '0;
	logic [3:0] pin_in, pin_out, pin_oe;
	logic [3:0] pull_low = 4'h0;
	int error_cnt = 0;
	int n_compared = 0;
	logic [7:0] map [12] = '{APC_ADDR_POLARITY, APC_ADDR_CFG_LOW, APC_ADDR_CFG_HIGH,
		APC_ADDR_CS0_LOW, APC_ADDR_CS0_HIGH, APC_ADDR_CS1_LOW, APC_ADDR_CS1_HIGH,
		APC_ADDR_CS2_LOW, APC_ADDR_CS2_HIGH, APC_ADDR_CS3_LOW, APC_ADDR_CS3_HIGH, 8'h80};
	logic [15:0] masks [4] = '{16'hffff, 16'hfffe, 16'hfffc, 16'hff00};
	logic [15:0] flips [5] = '{16'h0001, 16'h0002, 16'h0004, 16'h0080, 16'h0100};
	apc_port i_apc_port (.core_clk(core_clk), .rst(rst), .sfr(sfr), .sfr_raddr(sfr_raddr),
		.sfr_rdata(sfr_rdata), .bus(bus), .aux_pin_in(pin_in), .aux_pin_out(pin_out),
		.aux_pin_oe(pin_oe));
	apc_pin_load i_apc_pin_load (.pin_out(pin_out), .pin_oe(pin_oe),
		.ext_pull_low(pull_low), .pin_level(pin_in));
	// 200 MHz core clock
	initial begin
		forever #2.5 core_clk = !core_clk;
	end
	task automatic stop_test();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	// one write pulse, then a quiet cycle so back-to-back calls never retoggle wr at once
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		sfr.addr = a;
		sfr.wdata = d;
		sfr.wr = 1'b1;
		@(negedge core_clk);
		sfr.wr = 1'b0;
		@(negedge core_clk);
	endtask
	task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
		sfr_raddr = a;
		@(negedge core_clk);
		check("register read", 16'(exp), 16'(sfr_rdata));
	endtask
	// one bus access: level while it lasts, idle level the cycle after release
	task automatic strobe(input logic [15:0] a, input logic r, input logic w, input int p,
		input logic lvl, input logic idle);
		bus.addr = a;
		bus.rd = r;
		bus.wr = w;
		@(negedge core_clk);
		check("pin during access", 16'(lvl), 16'(pin_out[p]));
		bus.rd = 1'b0;
		bus.wr = 1'b0;
		@(negedge core_clk);
		check("pin after access", 16'(idle), 16'(pin_out[p]));
	endtask
	// watchdog against a hung run
	initial begin
		repeat (20000) @(posedge core_clk);
		error_cnt++;
		$display("[ERR] run length expected done seen hang");
		stop_test();
	end
	initial begin
		repeat (4) @(negedge core_clk);
		rst = 1'b0;
		check("oe after reset", 16'h0, 16'(pin_oe));
		foreach (map[i]) rd_reg(map[i], 8'h00);
		rd_reg(APC_ADDR_DATA, 8'h0f);
		foreach (map[i]) wr_reg(map[i], 8'hff - 8'(i));
		rd_reg(map[0], 8'hf0);
		for (int i = 1; i < 11; i++) rd_reg(map[i], 8'hff - 8'(i));
		rd_reg(map[11], 8'h00);
		$display("test registers done");
		wr_reg(APC_ADDR_CFG_LOW, 8'h00);
		wr_reg(APC_ADDR_CFG_HIGH, 8'h00);
		wr_reg(APC_ADDR_DATA, 8'ha5);
		@(negedge core_clk);
		check("gpio out", 16'h5, 16'(pin_out));
		check("gpio oe", 16'ha, 16'(pin_oe));
		pull_low = 4'h4;
		rd_reg(APC_ADDR_DATA, 8'h01);
		pull_low = 4'h0;
		$display("test gpio done");
		wr_reg(APC_ADDR_POLARITY, 8'hf0);
		for (int p = 0; p < 4; p++) begin
			wr_reg(APC_ADDR_CFG_LOW, p < 2 ? 8'h0c << (4 * p) : 8'h00);
			wr_reg(APC_ADDR_CFG_HIGH, p > 1 ? 8'h0c << (4 * (p - 2)) : 8'h00);
			wr_reg(map[4 + 2 * p], 8'h10 + 8'(p));
			wr_reg(map[3 + 2 * p], 8'h20 + 8'(p));
			strobe({8'h10 + 8'(p), 8'h20 + 8'(p)}, 1'b1, 1'b0, p, 1'b1, 1'b0);
			strobe({8'h10 + 8'(p), 8'h21 + 8'(p)}, 1'b0, 1'b1, p, 1'b0, 1'b0);
		end
		$display("test pin fields done");
		wr_reg(APC_ADDR_CS3_HIGH, 8'h5a);
		wr_reg(APC_ADDR_CS3_LOW, 8'h3c);
		for (int c = 0; c < 4; c++) begin
			wr_reg(APC_ADDR_CFG_HIGH, 8'hc0 | 8'(c << 4));
			foreach (flips[f]) begin
				strobe(16'h5a3c ^ flips[f], 1'b0, 1'b1, 3,
					(flips[f] & masks[c]) == 16'h0, 1'b0);
			end
		end
		$display("test compare lengths done");
		wr_reg(APC_ADDR_POLARITY, 8'h70);
		for (int f = 0; f < 4; f++) begin
			wr_reg(APC_ADDR_CFG_HIGH, 8'(f << 6));
			strobe(16'h5a3c, 1'b1, 1'b0, 3, f == 0 ? 1'b0 : !f[0], f == 0 ? 1'b0 : 1'b1);
			strobe(16'h5a3c, 1'b0, 1'b1, 3, f == 0 ? 1'b0 : !f[1], f == 0 ? 1'b0 : 1'b1);
		end
		wr_reg(APC_ADDR_CFG_LOW, 8'h0a);
		wr_reg(APC_ADDR_CS0_HIGH, 8'h12);
		wr_reg(APC_ADDR_CS0_LOW, 8'h34);
		strobe(16'h1237, 1'b0, 1'b1, 0, 1'b1, 1'b0);
		strobe(16'h1238, 1'b0, 1'b1, 0, 1'b0, 1'b0);
		wr_reg(APC_ADDR_CFG_LOW, 8'h06);
		strobe(16'h1235, 1'b1, 1'b0, 0, 1'b1, 1'b0);
		strobe(16'h1235, 1'b0, 1'b1, 0, 1'b0, 1'b0);
		check("strobe oe", 16'h1, 16'(pin_oe[0]));
		wr_reg(APC_ADDR_CFG_LOW, 8'h80);
		strobe(16'h1121, 1'b0, 1'b1, 1, 1'b1, 1'b0);
		strobe(16'h1121, 1'b1, 1'b0, 1, 1'b0, 1'b0);
		$display("test functions and polarity done");
		stop_test();
	end
endmodule
